// >>> eql_regs.sv
/*
 * Egress queue 2 / queue 3 rate limit register bank for switch ports 2 to 4,
 * plus the fixed read-only test registers.
 * Assumes the register port and the queue mode inputs come from logic on sys_clk;
 * the shaper and the rate-select table sit outside and consume the outputs.
 */
`timescale 1ns/1ps

module eql_regs
    import eql_pkg::*;
(
    input  wire logic                                sys_clk,
    input  wire logic                                reset,
    input  wire logic [ADDR_W-1:0]                   reg_addr,
    input  wire logic                                reg_wr,
    input  wire logic [DATA_W-1:0]                   reg_wdata,
    input  wire logic                                reg_rd,
    output      logic [DATA_W-1:0]                   reg_rdata,
    output      logic                                reg_rvalid,
    input  wire eql_qmode_e [NPORT-1:0]              queue_mode,
    output      logic [NPORT-1:0][LIMIT_W-1:0]       q2_limit,
    output      logic [NPORT-1:0][LIMIT_W-1:0]       q3_limit,
    output      logic [NPORT-1:0]                    q2_lowest,
    output      logic [NPORT-1:0]                    q2_low,
    output      logic [NPORT-1:0]                    q3_exact,
    output      logic [NPORT-1:0]                    q_ratio
);

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    function automatic logic [NPORT-1:0] port_hit(
        input logic [ADDR_W-1:0]             addr,
        input logic [NPORT-1:0][ADDR_W-1:0]  table_off
    );
        logic [NPORT-1:0] hit;
        hit = '0;
        for (int p = 0; p < NPORT; p++)
        begin
            hit[p] = (addr == table_off[p]);
        end
        return hit;
    endfunction

    logic [NPORT-1:0] q2_hit;
    logic [NPORT-1:0] q3_hit;

    always_comb
    begin
        q2_hit = port_hit(reg_addr, Q2_LIMIT_OFF);
        q3_hit = port_hit(reg_addr, Q3_LIMIT_OFF);
    end

    // ----------------------------------------------------------------
    // limit registers
    // ----------------------------------------------------------------
    logic [NPORT-1:0][LIMIT_W-1:0] q2_limit_r;
    logic [NPORT-1:0][LIMIT_W-1:0] q2_limit_nxt;
    logic [NPORT-1:0][LIMIT_W-1:0] q3_limit_r;
    logic [NPORT-1:0][LIMIT_W-1:0] q3_limit_nxt;

    generate
        for (genvar p = 0; p < NPORT; p++)
        begin : g_limit
            // bit 7 of the write data is dropped: the reserved bit has no storage
            always_comb
            begin
                q2_limit_nxt[p] = q2_limit_r[p];
                q3_limit_nxt[p] = q3_limit_r[p];
                if (reg_wr && q2_hit[p])
                begin
                    q2_limit_nxt[p] = reg_wdata[LIMIT_W-1:0];
                end
                if (reg_wr && q3_hit[p])
                begin
                    q3_limit_nxt[p] = reg_wdata[LIMIT_W-1:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            q2_limit_r <= {NPORT{LIMIT_RST}};
            q3_limit_r <= {NPORT{LIMIT_RST}};
        end
        else
        begin
            q2_limit_r <= q2_limit_nxt;
            q3_limit_r <= q3_limit_nxt;
        end
    end

    assign q2_limit = q2_limit_r;
    assign q3_limit = q3_limit_r;

    // ----------------------------------------------------------------
    // queue role flags for the shaper
    // ----------------------------------------------------------------
    logic [NPORT-1:0] q2_lowest_r;
    logic [NPORT-1:0] q2_lowest_nxt;
    logic [NPORT-1:0] q2_low_r;
    logic [NPORT-1:0] q2_low_nxt;
    logic [NPORT-1:0] q3_exact_r;
    logic [NPORT-1:0] q3_exact_nxt;
    logic [NPORT-1:0] q_ratio_r;
    logic [NPORT-1:0] q_ratio_nxt;

    // the illegal mode code is treated as single queue: no shaping roles at all
    always_comb
    begin
        for (int p = 0; p < NPORT; p++)
        begin
            q2_lowest_nxt[p] = 1'b0;
            q2_low_nxt[p]    = 1'b0;
            q3_exact_nxt[p]  = 1'b0;
            q_ratio_nxt[p]   = 1'b0;
            unique case (queue_mode[p])
                QM_FOUR:
                begin
                    q2_lowest_nxt[p] = 1'b1;
                    q3_exact_nxt[p]  = 1'b1;
                    q_ratio_nxt[p]   = 1'b1;
                end
                QM_TWO:
                begin
                    q2_low_nxt[p]    = 1'b1;
                    q_ratio_nxt[p]   = 1'b1;
                end
                QM_ONE:
                begin
                    q_ratio_nxt[p]   = 1'b0;
                end
                default:
                begin
                    q_ratio_nxt[p]   = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            q2_lowest_r <= '0;
            q2_low_r    <= '0;
            q3_exact_r  <= '0;
            q_ratio_r   <= '0;
        end
        else
        begin
            q2_lowest_r <= q2_lowest_nxt;
            q2_low_r    <= q2_low_nxt;
            q3_exact_r  <= q3_exact_nxt;
            q_ratio_r   <= q_ratio_nxt;
        end
    end

    assign q2_lowest = q2_lowest_r;
    assign q2_low    = q2_low_r;
    assign q3_exact  = q3_exact_r;
    assign q_ratio   = q_ratio_r;

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic              rvalid_r;
    logic              rvalid_nxt;

    // test registers are constants: writes to them find no storage
    always_comb
    begin
        rvalid_nxt = reg_rd;
        rdata_nxt  = UNMAPPED_VAL;
        if (reg_rd)
        begin
            unique case (reg_addr)
                TEST_RESERVED_A_OFF:    rdata_nxt = TEST_RESERVED_A_VAL;
                RESERVED_CONTROL_B_OFF: rdata_nxt = RESERVED_CONTROL_B_VAL;
                TEST_RESERVED_C_OFF:    rdata_nxt = TEST_RESERVED_C_VAL;
                TEST_RESERVED_D_OFF:    rdata_nxt = TEST_RESERVED_D_VAL;
                TEST_RESERVED_E_OFF:    rdata_nxt = TEST_RESERVED_E_VAL;
                default:
                begin
                    for (int p = 0; p < NPORT; p++)
                    begin
                        if (q2_hit[p])
                        begin
                            rdata_nxt = {1'b0, q2_limit_r[p]};
                        end
                        if (q3_hit[p])
                        begin
                            rdata_nxt = {1'b0, q3_limit_r[p]};
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            rdata_r  <= UNMAPPED_VAL;
            rvalid_r <= 1'b0;
        end
        else
        begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign reg_rdata  = rdata_r;
    assign reg_rvalid = rvalid_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_q2_write: assert property (@(posedge sys_clk) disable iff (reset)
        (reg_wr && reg_addr == Q2_LIMIT_OFF[0]) |=> q2_limit[0] == $past(reg_wdata[LIMIT_W-1:0]))
        else $error("queue 2 limit did not take the written code");

    chk_q3_write: assert property (@(posedge sys_clk) disable iff (reset)
        (reg_wr && reg_addr == Q3_LIMIT_OFF[2]) |=> q3_limit[2] == $past(reg_wdata[LIMIT_W-1:0]))
        else $error("queue 3 limit did not take the written code");

    chk_q2_readback: assert property (@(posedge sys_clk) disable iff (reset)
        (reg_rd && !reg_wr && reg_addr == Q2_LIMIT_OFF[1]) ##1 (reg_rd && reg_addr == Q2_LIMIT_OFF[1])
        |=> reg_rvalid && reg_rdata[DATA_W-1] == 1'b0 && reg_rdata == $past(reg_rdata))
        else $error("limit readback unstable or bit 7 set");

    chk_test_a_fixed: assert property (@(posedge sys_clk) disable iff (reset)
        (reg_rd && reg_addr == TEST_RESERVED_A_OFF) |=> reg_rvalid && reg_rdata == TEST_RESERVED_A_VAL)
        else $error("test register a not 0x80");

    chk_ctrl_b_fixed: assert property (@(posedge sys_clk) disable iff (reset)
        (reg_wr && reg_addr == RESERVED_CONTROL_B_OFF) ##1 (reg_rd && reg_addr == RESERVED_CONTROL_B_OFF)
        |=> reg_rdata == RESERVED_CONTROL_B_VAL)
        else $error("reserved control register changed by write");

    chk_test_d_fixed: assert property (@(posedge sys_clk) disable iff (reset)
        (reg_rd && reg_addr == TEST_RESERVED_D_OFF) |=> reg_rdata == TEST_RESERVED_D_VAL)
        else $error("test register d not 0x32");

    chk_q2_role: assert property (@(posedge sys_clk) disable iff (reset)
        // the edge that releases reset still loads reset values, so it starts no attempt
        (!reset && queue_mode[0] == QM_TWO) |=> q2_low[0] && !q2_lowest[0] && !q3_exact[0])
        else $error("queue 2 role wrong in two-queue mode");

    chk_q3_exact: assert property (@(posedge sys_clk) disable iff (reset)
        !reset |=> q3_exact[1] == ($past(queue_mode[1]) == QM_FOUR))
        else $error("queue 3 exact flag does not follow four-queue mode");

    chk_ratio_use: assert property (@(posedge sys_clk) disable iff (reset)
        (queue_mode[2] == QM_ONE) |=> !q_ratio[2])
        else $error("ratio use flagged with a single queue");

    chk_rvalid_pulse: assert property (@(posedge sys_clk) disable iff (reset)
        reg_rd |=> reg_rvalid)
        else $error("read not answered in one cycle");

endmodule // eql_regs

// >>> eql_pkg.sv
/*
 * Constants for the per-port egress queue 2 and queue 3 rate limit registers
 * and the reserved read-only test registers.
 * Assumes a byte-wide management register port in the switch core clock domain.
 */
package eql_pkg;

    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int unsigned NPORT      = 3;
    localparam int unsigned LIMIT_W    = 7;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned ADDR_W     = 8;

    // ----------------------------------------------------------------
    // register offsets, index 0 is switch port 2
    // ----------------------------------------------------------------
    localparam logic [NPORT-1:0][ADDR_W-1:0] Q2_LIMIT_OFF = {8'hED, 8'hDD, 8'hCD};
    localparam logic [NPORT-1:0][ADDR_W-1:0] Q3_LIMIT_OFF = {8'hEE, 8'hDE, 8'hCE};
    localparam logic [ADDR_W-1:0] TEST_RESERVED_A_OFF      = 8'hBF;
    localparam logic [ADDR_W-1:0] RESERVED_CONTROL_B_OFF   = 8'hCF;
    localparam logic [ADDR_W-1:0] TEST_RESERVED_C_OFF      = 8'hDF;
    localparam logic [ADDR_W-1:0] TEST_RESERVED_D_OFF      = 8'hEF;
    localparam logic [ADDR_W-1:0] TEST_RESERVED_E_OFF      = 8'hFF;

    // ----------------------------------------------------------------
    // reset and fixed values
    // ----------------------------------------------------------------
    localparam logic [LIMIT_W-1:0] LIMIT_RST               = 7'h00;
    localparam logic [DATA_W-1:0]  TEST_RESERVED_A_VAL     = 8'h80;
    localparam logic [DATA_W-1:0]  RESERVED_CONTROL_B_VAL  = 8'h15;
    localparam logic [DATA_W-1:0]  TEST_RESERVED_C_VAL     = 8'h0C;
    localparam logic [DATA_W-1:0]  TEST_RESERVED_D_VAL     = 8'h32;
    localparam logic [DATA_W-1:0]  TEST_RESERVED_E_VAL     = 8'h00;
    localparam logic [DATA_W-1:0]  UNMAPPED_VAL            = 8'h00;

    // ----------------------------------------------------------------
    // egress queue configuration of a port
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        QM_ONE,
        QM_TWO,
        QM_FOUR
    } eql_qmode_e;

endpackage

// >>> tb.sv
/*
 * Self-checking bench for the egress queue limit register bank.
 * Assumes eql_pkg and eql_regs are compiled first; the bench drives all ports.
 */
`timescale 1ns/1ps

module tb
    import eql_pkg::*;
;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wd;
        logic [7:0] exp;
        logic [7:0] rst;
    } eql_row_s;

    logic                          sys_clk;
    logic                          reset;
    logic [ADDR_W-1:0]             reg_addr;
    logic                          reg_wr;
    logic [DATA_W-1:0]             reg_wdata;
    logic                          reg_rd;
    logic [DATA_W-1:0]             reg_rdata;
    logic                          reg_rvalid;
    eql_qmode_e [NPORT-1:0]        queue_mode;
    logic [NPORT-1:0][LIMIT_W-1:0] q2_limit;
    logic [NPORT-1:0][LIMIT_W-1:0] q3_limit;
    logic [NPORT-1:0]              q2_lowest;
    logic [NPORT-1:0]              q2_low;
    logic [NPORT-1:0]              q3_exact;
    logic [NPORT-1:0]              q_ratio;
    int                            fails;
    int                            check_count;
    int                            cycles;
    int                            i;
    // bit 7 set in some writes: it must be dropped; fixed registers must ignore writes
    eql_row_s                      rows [12] = '{
        '{8'hCD, 8'h85, 8'h05, 8'h00}, '{8'hCE, 8'hFF, 8'h7F, 8'h00},
        '{8'hDD, 8'h2A, 8'h2A, 8'h00}, '{8'hDE, 8'h81, 8'h01, 8'h00},
        '{8'hED, 8'h40, 8'h40, 8'h00}, '{8'hEE, 8'h93, 8'h13, 8'h00},
        '{8'hBF, 8'hFF, 8'h80, 8'h80}, '{8'hCF, 8'h00, 8'h15, 8'h15},
        '{8'hDF, 8'hFF, 8'h0C, 8'h0C}, '{8'hEF, 8'h00, 8'h32, 8'h32},
        '{8'hFF, 8'hAA, 8'h00, 8'h00}, '{8'hA5, 8'h5A, 8'h00, 8'h00}};

    eql_regs eql_regs_i (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .reg_addr   (reg_addr),
        .reg_wr     (reg_wr),
        .reg_wdata  (reg_wdata),
        .reg_rd     (reg_rd),
        .reg_rdata  (reg_rdata),
        .reg_rvalid (reg_rvalid),
        .queue_mode (queue_mode),
        .q2_limit   (q2_limit),
        .q3_limit   (q3_limit),
        .q2_lowest  (q2_lowest),
        .q2_low     (q2_low),
        .q3_exact   (q3_exact),
        .q_ratio    (q_ratio)
    );

    // ----------------------------------------------------------------
    // clock, timeout and shared tasks
    // ----------------------------------------------------------------
    always #20 sys_clk = ~sys_clk;

    // the whole run needs about 130 cycles, so 1000 leaves ample margin
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 1000)
        begin
            fails = fails + 1;
            results();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count = check_count + 1;
        if (got !== exp)
        begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            fails = fails + 1;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask

    // read data stands one cycle only, then falls back to zero
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        chk("rvalid", 32'h1, 32'(reg_rvalid));
        chk("rdata", 32'(e), 32'(reg_rdata));
        @(posedge sys_clk);
        #1;
        chk("rvalid_after", 32'h0, 32'(reg_rvalid));
        chk("rdata_after", 32'h0, 32'(reg_rdata));
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        sys_clk     = 1'b0;
        reset       = 1'b1;
        reg_addr    = 8'h00;
        reg_wr      = 1'b0;
        reg_wdata   = 8'h00;
        reg_rd      = 1'b0;
        queue_mode  = '{default: QM_ONE};
        fails       = 0;
        check_count = 0;
        cycles      = 0;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;

        for (i = 0; i < 12; i++)
        begin
            rd(rows[i].addr, rows[i].rst);
            wr(rows[i].addr, rows[i].wd);
            rd(rows[i].addr, rows[i].exp);
        end
        chk("q2_limit", 32'({7'h40, 7'h2A, 7'h05}), 32'(q2_limit));
        chk("q3_limit", 32'({7'h13, 7'h01, 7'h7F}), 32'(q3_limit));
        $display("test register table done");

        for (i = 0; i < 4; i++)
        begin
            @(posedge sys_clk);
            queue_mode <= '{default: eql_qmode_e'(i)};
            @(posedge sys_clk);
            #1;
            chk("q2_lowest", 32'({NPORT{i == 2}}), 32'(q2_lowest));
            chk("q2_low", 32'({NPORT{i == 1}}), 32'(q2_low));
            chk("q3_exact", 32'({NPORT{i == 2}}), 32'(q3_exact));
            chk("q_ratio", 32'({NPORT{i == 1 || i == 2}}), 32'(q_ratio));
        end
        @(posedge sys_clk);
        queue_mode <= '{QM_FOUR, QM_TWO, QM_ONE};
        @(posedge sys_clk);
        #1;
        chk("mixed_lowest", 32'h4, 32'(q2_lowest));
        chk("mixed_low", 32'h2, 32'(q2_low));
        chk("mixed_exact", 32'h4, 32'(q3_exact));
        chk("mixed_ratio", 32'h6, 32'(q_ratio));
        $display("test queue modes done");

        // ----------------------------------------------------------------
        // awkward cases
        // ----------------------------------------------------------------
        // read and write of one register in the same cycle: read sees the old value
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_rd    <= 1'b1;
        reg_addr  <= 8'hDD;
        reg_wdata <= 8'hEE;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
        #1;
        chk("rdata_old", 32'h2A, 32'(reg_rdata));
        chk("q2_limit_new", 32'h6E, 32'(q2_limit[1]));
        $display("test same cycle done");

        // back-to-back reads of one limit, then a fixed register written and read back in the next cycle
        @(posedge sys_clk);
        reg_rd    <= 1'b1;
        reg_addr  <= 8'hDD;
        @(posedge sys_clk);
        #1;
        chk("rdata_b2b_first", 32'h6E, 32'(reg_rdata));
        @(posedge sys_clk);
        reg_rd    <= 1'b0;
        reg_wr    <= 1'b1;
        reg_addr  <= 8'hCF;
        reg_wdata <= 8'hEA;
        #1;
        chk("rdata_b2b_second", 32'h6E, 32'(reg_rdata));
        chk("rvalid_b2b", 32'h1, 32'(reg_rvalid));
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        @(posedge sys_clk);
        reg_rd    <= 1'b0;
        #1;
        chk("ctrl_b_after_wr", 32'h15, 32'(reg_rdata));
        $display("test back to back done");

        // reset in mid-run clears the limits at once, without a clock edge
        @(posedge sys_clk);
        reset <= 1'b1;
        #1;
        chk("q2_rst", 32'h0, 32'(q2_limit));
        chk("q3_rst", 32'h0, 32'(q3_limit));
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        rd(8'hEE, 8'h00);
        rd(8'hEF, 8'h32);
        $display("test second reset done");
        results();
    end
endmodule // tb
